// [dv/acdc_top_sva.sv]
// assertion checker of the aligned clock divider configuration block
`timescale 1ns/1ns
module acdc_top_sva
   import acdc_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        sysResetReq,
   input wire logic        standbyTick,
   input wire acdcFlash_t  flashCfg,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire acdcClkEn_t  clkEn,
   input wire logic        clockCtrlResetN,
   input wire logic        pllResetOut
);
   logic       pllInitShadow_q;
   logic       memEnShadow_q;
   logic       persistShadow_q;
   logic [3:0] initAge_q;
   // shadow of the bits that gate the memory clock, force standby and keep the reset
   always_ff @(posedge clk) begin
      if (srst) begin
         pllInitShadow_q <= 1'b1;
         memEnShadow_q   <= 1'b0;
         persistShadow_q <= 1'b0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == ACDC_CFG1_OFFSET) begin
            pllInitShadow_q <= pwdata[PLL_INIT_BIT];
            memEnShadow_q   <= pwdata[MEMCLK_EN_BIT];
         end
         if (flashCfg.load) begin
            persistShadow_q <= flashCfg.persist;
         end
      end
   end
   // cycles the pll init bit has stood; a mux may wait a few cycles for an input gap
   always_ff @(posedge clk) begin
      if (srst) begin
         initAge_q <= 4'hF;
      end else if (!pllInitShadow_q) begin
         initAge_q <= 4'h0;
      end else if (initAge_q != 4'hF) begin
         initAge_q <= initAge_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_reset_quiet;
      $past(srst) |-> clkEn == '0 && !pready && !clockCtrlResetN;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
   property p_pll_inv;
      pllResetOut == !$past(clockCtrlResetN);
   endproperty
   a_pll_inv: assert property (p_pll_inv) else $error("pll reset not inverse");
   property p_sys_reset;
      sysResetReq && !persistShadow_q |=> !clockCtrlResetN;
   endproperty
   a_sys_reset: assert property (p_sys_reset) else $error("reset not applied");
   property p_persist_hold;
      persistShadow_q && clockCtrlResetN |=> clockCtrlResetN;
   endproperty
   a_persist_hold: assert property (p_persist_hold) else $error("reset not kept");
   property p_apb_answer;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("bad ready timing");
   property p_apb_err;
      pready |-> pslverr == (paddr != ACDC_CFG1_OFFSET);
   endproperty
   a_apb_err: assert property (p_apb_err) else $error("bad error response");
   property p_mem_gate;
      !(memEnShadow_q && !pllInitShadow_q) && !$past(memEnShadow_q && !pllInitShadow_q)
         |-> !clkEn.memctrlClock;
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory clock not gated");
   property p_standby_mux;
      pllInitShadow_q && initAge_q == 4'hF && $past(clockCtrlResetN)
         && $past(clockCtrlResetN, 2) |-> clkEn[7:4] == {4{$past(standbyTick)}};
   endproperty
   a_standby_mux: assert property (p_standby_mux) else $error("mux not on standby");
endmodule
bind acdc_top acdc_top_sva u_acdc_top_sva (.clk(clk), .srst(srst),
   .sysResetReq(sysResetReq), .standbyTick(standbyTick), .flashCfg(flashCfg), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .clkEn(clkEn), .clockCtrlResetN(clockCtrlResetN),
   .pllResetOut(pllResetOut));

// [dv/acdc_top_tb.sv]
// self-checking testbench of the aligned clock divider configuration block
`timescale 1ns/1ns
module acdc_top_tb
   import acdc_pkg::*;
;
   logic        clk, srst, sysResetReq, standbyTick, psel, penable, pwrite;
   logic        pready, pslverr, clockCtrlResetN, pllResetOut, rdErr;
   logic [31:0] paddr, pwdata, prdata, rdData, shadow;
   logic [3:0]  sbCnt_q;
   acdcFlash_t  flashCfg;
   acdcClkEn_t  clkEn;
   int          nFail, testsRun;

   acdc_top u_acdc_top (.clk(clk), .srst(srst), .sysResetReq(sysResetReq),
      .standbyTick(standbyTick), .flashCfg(flashCfg), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clkEn(clkEn), .clockCtrlResetN(clockCtrlResetN),
      .pllResetOut(pllResetOut));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // standby clock: one pulse every five cycles
   always @(posedge clk) begin
      if (srst) begin
         sbCnt_q     <= 4'h0;
         standbyTick <= 1'b0;
      end else begin
         sbCnt_q     <= (sbCnt_q == 4'h4) ? 4'h0 : sbCnt_q + 4'h1;
         standbyTick <= (sbCnt_q == 4'h4);
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finishTest();
      $display("comparisons %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         nFail++;
         finishTest();
      end else begin
         rdData  = prdata;
         rdErr   = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // cycles between pulses of one enable, measured after the ratio has settled
   task automatic checkPeriod(input int b, input int e);
      int   p;
      logic lost;
      lost = 1'b0;
      for (int k = 0; k < 4; k++) begin
         p = 0;
         do begin
            @(negedge clk);
            p++;
         end while (clkEn[b] !== 1'b1 && p < 300);
         lost = lost | (clkEn[b] !== 1'b1);
      end
      if (lost) begin
         nFail++;
         finishTest();
      end else begin
         check(p, e);
      end
   endtask

   task automatic flash(input logic p, input logic m);
      @(posedge clk);
      flashCfg <= '{1'b1, p, m, RATIO_4};
      @(posedge clk);
      flashCfg.load <= 1'b0;
   endtask

   task automatic sysPulse(input logic expN);
      @(posedge clk);
      sysResetReq <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(clockCtrlResetN, expN);
      check(pllResetOut, !expN);
      @(posedge clk);
      sysResetReq <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check({clockCtrlResetN, pllResetOut}, 2'h2);
   endtask

   task automatic testResetFlash();
      apb(1'b0, ACDC_CFG1_OFFSET, ACDC_ZERO_WORD);
      check(rdData, ACDC_CFG1_RESET);
      checkPeriod(7, 5);
      flash(1'b0, 1'b0);
      sysPulse(1'b0);
      flash(1'b1, 1'b0);
      sysPulse(1'b1);
      apb(1'b0, ACDC_CFG1_OFFSET, ACDC_ZERO_WORD);
      check(rdData, 32'h0680_0000);
   endtask

   task automatic testMask();
      int lsb [6] = '{PBUS0_LSB, PBUS1_LSB, SUBSYS_LSB, FIF0_LSB, FIF1_LSB, DDR_LSB};
      logic [31:0] w;
      w = 32'hFBFF_FEFF;
      foreach (lsb[i]) w[lsb[i] +: RATIO_W] = RATIO_32;
      w[FIRST_STAGE_LSB +: FIRST_W] = FIRST_3;
      apb(1'b1, ACDC_CFG1_OFFSET, w);
      apb(1'b0, ACDC_CFG1_OFFSET, ACDC_ZERO_WORD);
      check(rdData, (w & 32'h043F_EFFF) | 32'h0280_0000);
      apb(1'b1, 32'h0000_0004, ACDC_ZERO_WORD);
      check(rdErr, 1'b1);
      apb(1'b0, 32'h0000_0004, ACDC_ZERO_WORD);
      check(rdErr, 1'b1);
      check(rdData, ACDC_ZERO_WORD);
      apb(1'b0, ACDC_CFG1_OFFSET, ACDC_ZERO_WORD);
      check(rdData, (w & 32'h043F_EFFF) | 32'h0280_0000);
   endtask

   // ratio fields change at run time here, as allowed outside the smallest variants
   task automatic testRatios();
      logic [RATIO_W-1:0] codes [6] = '{RATIO_1, RATIO_2, RATIO_4, RATIO_8, RATIO_16, RATIO_32};
      shadow = ACDC_ZERO_WORD;
      for (int f = 0; f < 3; f++) begin
         for (int c = 0; c < 6; c++) begin
            shadow[FIRST_STAGE_LSB +: FIRST_W] = f[FIRST_W-1:0];
            shadow[SUBSYS_LSB +: RATIO_W] = codes[c];
            apb(1'b1, ACDC_CFG1_OFFSET, shadow);
            checkPeriod(7, (1 << c) * (f + 1));
         end
      end
      shadow[SUBSYS_LSB +: RATIO_W] = 3'h3;
      shadow[FIRST_STAGE_LSB +: FIRST_W] = 2'h3;
      apb(1'b1, ACDC_CFG1_OFFSET, shadow);
      checkPeriod(7, 96);
      shadow = ACDC_ZERO_WORD;
      shadow[PBUS0_LSB +: RATIO_W] = RATIO_2;
      shadow[PBUS1_LSB +: RATIO_W] = RATIO_4;
      shadow[DDR_LSB +: RATIO_W]   = RATIO_8;
      shadow[FIF0_LSB +: RATIO_W]  = RATIO_16;
      shadow[FIF1_LSB +: RATIO_W]  = RATIO_32;
      apb(1'b1, ACDC_CFG1_OFFSET, shadow);
      for (int i = 0; i < 5; i++) begin
         checkPeriod(6 - i, 2 << i);
      end
      checkPeriod(1, 4);
   endtask

   task automatic testMemMux();
      int n;
      for (int on = 1; on >= 0; on--) begin
         shadow[MEMCLK_EN_BIT] = on[0];
         apb(1'b1, ACDC_CFG1_OFFSET, shadow);
         @(posedge clk);
         n = 0;
         repeat (20) begin
            @(negedge clk);
            n += (clkEn.memctrlClock === 1'b1);
         end
         check(n, 20 * on);
      end
      shadow[SUBSYS_LSB +: RATIO_W] = RATIO_8;
      apb(1'b1, ACDC_CFG1_OFFSET, shadow);
      flash(1'b1, 1'b1);
      for (int b = 7; b > 3; b--) begin
         checkPeriod(b, 5);
      end
      flash(1'b1, 1'b0);
      checkPeriod(7, 8);
      shadow[MEMCLK_EN_BIT] = 1'b1;
      for (int pi = 1; pi >= 0; pi--) begin
         shadow[PLL_INIT_BIT] = pi[0];
         apb(1'b1, ACDC_CFG1_OFFSET, shadow);
         checkPeriod(7, (pi == 1) ? 5 : 8);
         n = 0;
         repeat (20) begin
            @(negedge clk);
            n += (clkEn.memctrlClock === 1'b1);
         end
         check(n, 20 - 20 * pi);
      end
   endtask

   initial begin
      {srst, sysResetReq, psel, penable, pwrite} = 5'h10;
      {paddr, pwdata, shadow} = '0;
      flashCfg = '0;
      nFail = 0;
      testsRun = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      testResetFlash();
      testMask();
      testRatios();
      testMemMux();
      finishTest();
   end
endmodule

// [src/acdc_pkg.sv]
// shared constants and types of the aligned clock divider configuration block
package acdc_pkg;

   // register map
   localparam logic [31:0] ACDC_CFG1_OFFSET = 32'h0000_0000;
   localparam logic [31:0] ACDC_CFG1_RESET  = 32'h0400_0000;
   localparam logic [31:0] ACDC_ZERO_WORD   = 32'h0000_0000;

   // field positions of aligned_clock_config_one
   localparam int FIRST_STAGE_LSB = 0;
   localparam int PBUS0_LSB       = 2;
   localparam int PBUS1_LSB       = 5;
   localparam int MEMCLK_EN_BIT   = 8;
   localparam int SUBSYS_LSB      = 9;
   localparam int MUX_SEL_BIT     = 12;
   localparam int FIF0_LSB        = 13;
   localparam int FIF1_LSB        = 16;
   localparam int DDR_LSB         = 19;
   localparam int BASE_LSB        = 22;
   localparam int PERSIST_BIT     = 25;
   localparam int PLL_INIT_BIT    = 26;

   localparam int RATIO_W  = 3;
   localparam int FIRST_W  = 2;
   localparam int DIVCNT_W = 5;

   // second stage ratio codes
   localparam logic [RATIO_W-1:0] RATIO_1  = 3'h0;
   localparam logic [RATIO_W-1:0] RATIO_2  = 3'h1;
   localparam logic [RATIO_W-1:0] RATIO_4  = 3'h2;
   localparam logic [RATIO_W-1:0] RATIO_8  = 3'h4;
   localparam logic [RATIO_W-1:0] RATIO_16 = 3'h5;
   localparam logic [RATIO_W-1:0] RATIO_32 = 3'h6;

   // first stage ratio codes
   localparam logic [FIRST_W-1:0] FIRST_1 = 2'h0;
   localparam logic [FIRST_W-1:0] FIRST_2 = 2'h1;
   localparam logic [FIRST_W-1:0] FIRST_3 = 2'h2;

   // divider terminal counts (ratio minus one)
   localparam logic [DIVCNT_W-1:0] TC_1  = 5'h00;
   localparam logic [DIVCNT_W-1:0] TC_2  = 5'h01;
   localparam logic [DIVCNT_W-1:0] TC_3  = 5'h02;
   localparam logic [DIVCNT_W-1:0] TC_4  = 5'h03;
   localparam logic [DIVCNT_W-1:0] TC_8  = 5'h07;
   localparam logic [DIVCNT_W-1:0] TC_16 = 5'h0F;
   localparam logic [DIVCNT_W-1:0] TC_32 = 5'h1F;

   // second stage divider indexes; the first four pass the aligned muxes
   localparam int DIV_SUBSYS = 0;
   localparam int DIV_PBUS0  = 1;
   localparam int DIV_PBUS1  = 2;
   localparam int DIV_DDR    = 3;
   localparam int DIV_FIF0   = 4;
   localparam int DIV_FIF1   = 5;
   localparam int DIV_BASE   = 6;
   localparam int NUM_DIV    = 7;
   localparam int NUM_MUX    = 4;

   typedef struct packed {
      logic                valid;
      logic [DIVCNT_W-1:0] tc;
   } acdcRatio_t;

   // flash configuration load
   typedef struct packed {
      logic               load;
      logic               persist;
      logic               muxSel;
      logic [RATIO_W-1:0] baseRatio;
   } acdcFlash_t;

   // one-cycle clock enables, each high at a rising edge of its clock
   typedef struct packed {
      logic subsystemClock;
      logic periphBus0Clock;
      logic periphBus1Clock;
      logic ddrIfaceClock;
      logic fabricIf0Clock;
      logic fabricIf1Clock;
      logic regeneratedBaseClock;
      logic memctrlClock;
   } acdcClkEn_t;

endpackage

// [src/acdc_top.sv]
// aligned clock divider configuration register, dividers, aligned muxes and reset control
//
// Operation
// - controller reset follows every system reset unless persistence bit set; then power-on only
// - pll reset output is the inverted active-low controller reset
// - ddr interface ratio accepts run-time writes with source clock running
// - second fabric interface ratio accepts run-time writes
// - first fabric interface ratio accepts run-time writes
// - one select moves all four aligned muxes: one standby, zero dividers
// - subsystem clock ratio accepts run-time writes
// - memory controller clock gated off at zero; not changed while running (this design accepts writes to it at any time)
// - second peripheral bus ratio accepts run-time writes
// - first peripheral bus ratio accepts run-time writes
// - first stage divides by 1, 2 or 3; 11 reserved; set statically (this design accepts run-time writes, applied at first stage wrap)
// - ratio codes 000,001,010,100,101,110 give 1,2,4,8,16,32; others reserved
// - pll init bit forces aligned muxes to standby and memory clock off
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ns
module acdc_top
   import acdc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        sysResetReq,
   input  wire logic        standbyTick,
   input  wire acdcFlash_t  flashCfg,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output acdcClkEn_t       clkEn,
   output logic             clockCtrlResetN,
   output logic             pllResetOut
);

   // ratio code to terminal count; reserved codes report invalid
   function automatic acdcRatio_t ratioDecode(input logic [RATIO_W-1:0] code);
      acdcRatio_t r;
      r.valid = 1'b1;
      case (code)
         RATIO_1:  r.tc = TC_1;
         RATIO_2:  r.tc = TC_2;
         RATIO_4:  r.tc = TC_4;
         RATIO_8:  r.tc = TC_8;
         RATIO_16: r.tc = TC_16;
         RATIO_32: r.tc = TC_32;
         default: begin
            r.valid = 1'b0;
            r.tc    = TC_1;
         end
      endcase
      return r;
   endfunction

   function automatic acdcRatio_t firstDecode(input logic [FIRST_W-1:0] code);
      acdcRatio_t r;
      r.valid = 1'b1;
      case (code)
         FIRST_1: r.tc = TC_1;
         FIRST_2: r.tc = TC_2;
         FIRST_3: r.tc = TC_3;
         default: begin
            r.valid = 1'b0;
            r.tc    = TC_1;
         end
      endcase
      return r;
   endfunction

   // register fields
   logic [FIRST_W-1:0]  firstStageRatio_q;
   logic [RATIO_W-1:0]  periphBus0Ratio_q;
   logic [RATIO_W-1:0]  periphBus1Ratio_q;
   logic                memctrlClkEn_q;
   logic [RATIO_W-1:0]  subsystemClockRatio_q;
   logic                alignedMuxSelect_q;
   logic [RATIO_W-1:0]  fabricIf0Ratio_q;
   logic [RATIO_W-1:0]  fabricIf1Ratio_q;
   logic [RATIO_W-1:0]  ddrIfaceRatio_q;
   logic [RATIO_W-1:0]  baseRegenRatio_q;
   logic                resetPersistenceBit_q;
   logic                pllInit_q;

   // bus
   logic                pready_q;
   logic                pslverr_q;
   logic [31:0]         prdata_q;
   logic                addrHit;
   logic                wrEn;
   logic [31:0]         readWord;

   // resets
   logic                clockCtrlResetN_q;
   logic                pllResetOut_q;
   logic                divRst;

   // dividers
   logic [DIVCNT_W-1:0] firstCnt_q;
   logic [DIVCNT_W-1:0] firstTc_q;
   logic                aTick_q;
   logic [RATIO_W-1:0]  ratioCode [NUM_DIV];
   logic [DIVCNT_W-1:0] divCnt_q  [NUM_DIV];
   logic [DIVCNT_W-1:0] divTc_q   [NUM_DIV];
   logic [DIVCNT_W-1:0] divTc_d   [NUM_DIV];
   logic [NUM_DIV-1:0]  divPulse_q;
   logic [NUM_MUX-1:0]  muxApplied_q;
   logic [NUM_MUX-1:0]  muxIdle;
   logic                muxForce;
   acdcClkEn_t          clkEn_q;
   acdcRatio_t          firstDec;
   acdcRatio_t          divDec    [NUM_DIV];

   // ---------------- APB slave ----------------
   assign addrHit = (paddr == ACDC_CFG1_OFFSET);
   assign wrEn    = psel & penable & pready_q & pwrite & addrHit;

   always_comb begin
      readWord                                       = ACDC_ZERO_WORD;
      readWord[FIRST_STAGE_LSB +: FIRST_W]           = firstStageRatio_q;
      readWord[PBUS0_LSB +: RATIO_W]                 = periphBus0Ratio_q;
      readWord[PBUS1_LSB +: RATIO_W]                 = periphBus1Ratio_q;
      readWord[MEMCLK_EN_BIT]                        = memctrlClkEn_q;
      readWord[SUBSYS_LSB +: RATIO_W]                = subsystemClockRatio_q;
      readWord[MUX_SEL_BIT]                          = alignedMuxSelect_q;
      readWord[FIF0_LSB +: RATIO_W]                  = fabricIf0Ratio_q;
      readWord[FIF1_LSB +: RATIO_W]                  = fabricIf1Ratio_q;
      readWord[DDR_LSB +: RATIO_W]                   = ddrIfaceRatio_q;
      readWord[BASE_LSB +: RATIO_W]                  = baseRegenRatio_q;
      readWord[PERSIST_BIT]                          = resetPersistenceBit_q;
      readWord[PLL_INIT_BIT]                         = pllInit_q;
   end

   // one wait-free access phase: ready rises in the cycle after setup
   always_ff @(posedge clk) begin
      if (srst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= ACDC_ZERO_WORD;
      end else begin
         pready_q  <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~addrHit;
         prdata_q  <= (psel & ~penable & ~pwrite & addrHit) ? readWord : ACDC_ZERO_WORD;
      end
   end

   // software-writable fields; run-time ratio writes apply at divider wrap
   always_ff @(posedge clk) begin
      if (srst) begin
         firstStageRatio_q     <= ACDC_CFG1_RESET[FIRST_STAGE_LSB +: FIRST_W];
         periphBus0Ratio_q     <= ACDC_CFG1_RESET[PBUS0_LSB +: RATIO_W];
         periphBus1Ratio_q     <= ACDC_CFG1_RESET[PBUS1_LSB +: RATIO_W];
         memctrlClkEn_q        <= ACDC_CFG1_RESET[MEMCLK_EN_BIT];
         subsystemClockRatio_q <= ACDC_CFG1_RESET[SUBSYS_LSB +: RATIO_W];
         fabricIf0Ratio_q      <= ACDC_CFG1_RESET[FIF0_LSB +: RATIO_W];
         fabricIf1Ratio_q      <= ACDC_CFG1_RESET[FIF1_LSB +: RATIO_W];
         ddrIfaceRatio_q       <= ACDC_CFG1_RESET[DDR_LSB +: RATIO_W];
         pllInit_q             <= ACDC_CFG1_RESET[PLL_INIT_BIT];
      end else if (wrEn) begin
         firstStageRatio_q     <= pwdata[FIRST_STAGE_LSB +: FIRST_W];
         periphBus0Ratio_q     <= pwdata[PBUS0_LSB +: RATIO_W];
         periphBus1Ratio_q     <= pwdata[PBUS1_LSB +: RATIO_W];
         memctrlClkEn_q        <= pwdata[MEMCLK_EN_BIT];
         subsystemClockRatio_q <= pwdata[SUBSYS_LSB +: RATIO_W];
         fabricIf0Ratio_q      <= pwdata[FIF0_LSB +: RATIO_W];
         fabricIf1Ratio_q      <= pwdata[FIF1_LSB +: RATIO_W];
         ddrIfaceRatio_q       <= pwdata[DDR_LSB +: RATIO_W];
         pllInit_q             <= pwdata[PLL_INIT_BIT];
      end
   end

   // flash-only fields; software writes to them are ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         resetPersistenceBit_q <= ACDC_CFG1_RESET[PERSIST_BIT];
         alignedMuxSelect_q    <= ACDC_CFG1_RESET[MUX_SEL_BIT];
         baseRegenRatio_q      <= ACDC_CFG1_RESET[BASE_LSB +: RATIO_W];
      end else if (flashCfg.load) begin
         resetPersistenceBit_q <= flashCfg.persist;
         alignedMuxSelect_q    <= flashCfg.muxSel;
         baseRegenRatio_q      <= flashCfg.baseRatio;
      end
   end

   // ---------------- reset control ----------------
   always_ff @(posedge clk) begin
      if (srst) begin
         clockCtrlResetN_q <= 1'b0;
         pllResetOut_q     <= 1'b1;
      end else begin
         clockCtrlResetN_q <= ~(sysResetReq & ~resetPersistenceBit_q);
         pllResetOut_q     <= ~clockCtrlResetN_q;
      end
   end

   assign divRst = srst | ~clockCtrlResetN_q;

   // ---------------- first stage divider ----------------
   assign firstDec = firstDecode(firstStageRatio_q);

   // reserved code keeps the last valid ratio
   always_ff @(posedge clk) begin
      if (divRst) begin
         firstCnt_q <= TC_1;
         firstTc_q  <= TC_1;
         aTick_q    <= 1'b0;
      end else if (firstCnt_q == TC_1) begin
         aTick_q    <= 1'b1;
         firstTc_q  <= firstDec.valid ? firstDec.tc : firstTc_q;
         firstCnt_q <= firstDec.valid ? firstDec.tc : firstTc_q;
      end else begin
         aTick_q    <= 1'b0;
         firstCnt_q <= firstCnt_q - TC_2;
      end
   end

   // ---------------- second stage dividers ----------------
   assign ratioCode[DIV_SUBSYS] = subsystemClockRatio_q;
   assign ratioCode[DIV_PBUS0]  = periphBus0Ratio_q;
   assign ratioCode[DIV_PBUS1]  = periphBus1Ratio_q;
   assign ratioCode[DIV_DDR]    = ddrIfaceRatio_q;
   assign ratioCode[DIV_FIF0]   = fabricIf0Ratio_q;
   assign ratioCode[DIV_FIF1]   = fabricIf1Ratio_q;
   assign ratioCode[DIV_BASE]   = baseRegenRatio_q;

   // new ratio taken only at period boundary; reserved code holds the old one
   always_comb begin
      for (int i = 0; i < NUM_DIV; i++) begin
         divDec[i]  = ratioDecode(ratioCode[i]);
         divTc_d[i] = divDec[i].valid ? divDec[i].tc : divTc_q[i];
      end
   end

   // every pulse is registered in the cycle after an intermediate tick, so divider outputs stay aligned
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_DIV; i++) begin
         if (divRst) begin
            divCnt_q[i]   <= TC_1;
            divTc_q[i]    <= TC_1;
            divPulse_q[i] <= 1'b0;
         end else if (aTick_q && divCnt_q[i] == TC_1) begin
            divPulse_q[i] <= 1'b1;
            divTc_q[i]    <= divTc_d[i];
            divCnt_q[i]   <= divTc_d[i];
         end else begin
            divPulse_q[i] <= 1'b0;
            if (aTick_q) begin
               divCnt_q[i] <= divCnt_q[i] - TC_2;
            end
         end
      end
   end

   // ---------------- aligned no-glitch muxes ----------------
   assign muxForce = alignedMuxSelect_q | pllInit_q;

   // a mux changes source only in a cycle where neither input pulses; a 1:1
   // divider enable never idles, so then only the standby gap is awaited
   always_comb begin
      for (int m = 0; m < NUM_MUX; m++) begin
         muxIdle[m] = !standbyTick &&
                      (!divPulse_q[m] || (firstTc_q == TC_1 && divTc_q[m] == TC_1));
      end
   end

   always_ff @(posedge clk) begin
      for (int m = 0; m < NUM_MUX; m++) begin
         if (srst) begin
            muxApplied_q[m] <= 1'b1;
         end else if (muxIdle[m]) begin
            muxApplied_q[m] <= muxForce;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clkEn_q <= '0;
      end else begin
         clkEn_q.subsystemClock       <= muxApplied_q[DIV_SUBSYS] ? standbyTick
                                                                  : divPulse_q[DIV_SUBSYS];
         clkEn_q.periphBus0Clock      <= muxApplied_q[DIV_PBUS0] ? standbyTick
                                                                 : divPulse_q[DIV_PBUS0];
         clkEn_q.periphBus1Clock      <= muxApplied_q[DIV_PBUS1] ? standbyTick
                                                                 : divPulse_q[DIV_PBUS1];
         clkEn_q.ddrIfaceClock        <= muxApplied_q[DIV_DDR] ? standbyTick
                                                               : divPulse_q[DIV_DDR];
         clkEn_q.fabricIf0Clock       <= divPulse_q[DIV_FIF0];
         clkEn_q.fabricIf1Clock       <= divPulse_q[DIV_FIF1];
         clkEn_q.regeneratedBaseClock <= divPulse_q[DIV_BASE];
         clkEn_q.memctrlClock         <= aTick_q & memctrlClkEn_q & ~pllInit_q;
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign clkEn           = clkEn_q;
   assign clockCtrlResetN = clockCtrlResetN_q;
   assign pllResetOut     = pllResetOut_q;

endmodule
